// [hdl/agptp_fifo.sv]
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module agptp_fifo
  import agptp_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];  // storage
  logic [AW:0]      wr_r;           // write pointer with wrap bit
  logic [AW:0]      rd_r;           // read pointer with wrap bit

  wire full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  wire push  = in_valid && !full;
  wire pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_r[AW-1:0]];

  // pointer update; memory has no reset
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wr_r[AW-1:0]] <= in_data;
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_r - rd_r) <= (AW+1)'(DEPTH))
    else $error("fifo occupancy above depth");
endmodule

// [hdl/agptp_pkg.sv]
// shared constants and carrier types for the graphics port target
package agptp_pkg;
  // frame-protocol command codes (pci encoding)
  localparam logic [3:0] CMD_MEM_READ    = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE   = 4'h7;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV  = 4'hF;
  // byte enables driven while returning read data
  localparam logic [3:0] RD_RETURN_CBE   = 4'h0;
  // grant status codes
  localparam logic [2:0] ST_RD_LOW       = 3'h0;
  localparam logic [2:0] ST_RD_HIGH      = 3'h1;
  localparam logic [2:0] ST_WR_LOW       = 3'h2;
  localparam logic [2:0] ST_WR_HIGH      = 3'h3;
  localparam logic [2:0] ST_START        = 3'h7;
  // default memory window, size as address bits
  localparam logic [31:0] MEM_BASE       = 32'h0000_0000;
  localparam int          MEM_BITS       = 28;
  // fifo depth and width
  localparam int          FIFO_DEPTH     = 16;
  localparam int          FIFO_WIDTH     = 36;
  // target stop timeout in data-phase clocks waited without a transfer
  localparam logic [2:0]  DEVSEL_WAIT    = 3'h3;

  // one address/data phase as seen on the port
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
  } agptp_phase_s;

  // enqueue mechanism chosen after reset
  typedef enum logic {AGPTP_PIPE, AGPTP_SIDEBAND} agptp_mech_e;
endpackage

// [hdl/agptp_target.sv]
// graphics port target signalling: frame protocol, enqueue capture, grant
`timescale 1ns/1ps
module agptp_target
  import agptp_pkg::*;
#(
  parameter logic [31:0] WIN_BASE = MEM_BASE,
  parameter int          WIN_BITS = MEM_BITS
)(
  input  wire logic        sys_clk,
  input  wire logic        system_reset_in_n,
  input  wire logic        rst,
  // mechanism chosen by configuration software
  input  wire logic        cfg_sideband_mode,
  // enqueue pins (sideband and pipelined) and read buffer full
  input  wire logic        sideband_strobe,
  input  wire logic [7:0]  sideband_address_bus,
  input  wire logic        port_pipe_n,
  input  wire logic        read_buffer_full_n,
  // frame protocol pins, split into in/out/enable
  input  wire logic        port_frame_n_i,
  output logic             port_frame_n_o,
  output logic             port_frame_n_oe,
  input  wire logic        port_initiator_ready_n,
  output logic             port_target_ready_n_o,
  output logic             port_target_ready_n_oe,
  output logic             port_stop_n_o,
  output logic             port_stop_n_oe,
  input  wire logic        port_device_select_n_i,
  output logic             port_device_select_n_o,
  output logic             port_device_select_n_oe,
  input  wire logic        port_parity_error_n_i,
  output logic             port_parity_error_n_o,
  output logic             port_parity_error_n_oe,
  input  wire logic        port_system_error_n,
  input  wire logic        port_request_n,
  output logic             port_grant_n,
  output logic [2:0]       grant_status,
  input  wire logic [31:0] port_addr_data_i,
  output logic [31:0]      port_addr_data_o,
  output logic             port_addr_data_oe,
  input  wire logic [3:0]  port_cmd_byte_en_n_i,
  output logic [3:0]       port_cmd_byte_en_n_o,
  output logic             port_cmd_byte_en_n_oe,
  input  wire logic        port_parity_i,
  output logic             port_parity_o,
  output logic             port_parity_oe,
  output logic             low_half_data_strobe_o,
  output logic             low_half_data_strobe_oe,
  output logic             high_half_data_strobe_o,
  output logic             high_half_data_strobe_oe,
  // user side: write data stream out, read data in
  output logic [35:0]      wr_data,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        rd_high_prio,
  output logic             rd_ready,
  // captured enqueue requests
  output logic [35:0]      req_data,
  output logic             req_valid,
  output logic             req_sideband,
  output logic             locked_seen,
  output logic             pci_system_error_n
);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // even parity over data and command lines
  function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
    even_par = ^{ad, cbe};
  endfunction

  // memory write commands
  function automatic logic is_write(input logic [3:0] c);
    is_write = (c == CMD_MEM_WRITE) || (c == CMD_MEM_WR_INV);
  endfunction

  // ------------------------------------------------------------------
  // reset and input synchronisers
  // ------------------------------------------------------------------
  logic [1:0] system_reset_in_n_r;       // system reset sync
  logic       port_rst;      // combined reset for port logic
  assign port_rst = rst | system_reset_in_n_r[1];

  logic [1:0] frame_s_r, irdy_s_r, devsel_s_r, pipe_s_r, rbf_s_r, req_s_r, serr_s_r;
  logic [1:0] sideband_strobe_s_r;
  logic [7:0] sba_m_r, sba_s_r;   // sideband address two stages
  logic       sideband_strobe_d_r;         // previous synchronised strobe
  agptp_phase_s ph_m_r, ph_s_r;  // address/data lines two stages
  logic [1:0]   par_s_r;

  // two flops on every pin input except parity error sense; first stage read only by second
  always_ff @(posedge sys_clk)
  begin
    system_reset_in_n_r    <= {system_reset_in_n_r[0], ~system_reset_in_n};
    frame_s_r  <= {frame_s_r[0], port_frame_n_i};
    irdy_s_r   <= {irdy_s_r[0], port_initiator_ready_n};
    devsel_s_r <= {devsel_s_r[0], port_device_select_n_i};
    pipe_s_r   <= {pipe_s_r[0], port_pipe_n};
    rbf_s_r    <= {rbf_s_r[0], read_buffer_full_n};
    req_s_r    <= {req_s_r[0], port_request_n};
    serr_s_r   <= {serr_s_r[0], port_system_error_n};
    sideband_strobe_s_r  <= {sideband_strobe_s_r[0], sideband_strobe};
    sba_m_r    <= sideband_address_bus;
    sba_s_r    <= sba_m_r;
    ph_m_r     <= '{ad: port_addr_data_i, cbe_n: port_cmd_byte_en_n_i};
    ph_s_r     <= ph_m_r;
    par_s_r    <= {par_s_r[0], port_parity_i};
    sideband_strobe_d_r  <= sideband_strobe_s_r[1];
  end

  wire frame_n  = frame_s_r[1];
  wire irdy_n   = irdy_s_r[1];
  wire pipe_n   = pipe_s_r[1];
  wire rbf_n    = rbf_s_r[1];
  wire sb_edge  = sideband_strobe_s_r[1] & ~sideband_strobe_d_r;

  // ------------------------------------------------------------------
  // mechanism latch and system error forwarding
  // ------------------------------------------------------------------
  agptp_mech_e mech_r;  // fixed after reset
  logic        cfg_done_r;
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      mech_r     <= AGPTP_PIPE;
      cfg_done_r <= 1'b0;
    end
    else if (!cfg_done_r)
    begin
      mech_r     <= cfg_sideband_mode ? AGPTP_SIDEBAND : AGPTP_PIPE;
      cfg_done_r <= 1'b1;
    end
  end
  assign req_sideband = (mech_r == AGPTP_SIDEBAND);

  // error held one slow tick so the slower domain sees it
  logic half_r, serr_r;
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      half_r <= 1'b0;
      serr_r <= 1'b1;
    end
    else
    begin
      half_r <= ~half_r;
      if (half_r)
        serr_r <= serr_s_r[1];
    end
  end
  assign pci_system_error_n = serr_r;

  // ------------------------------------------------------------------
  // enqueue capture: pipelined or sideband, never both
  // ------------------------------------------------------------------
  logic [35:0] req_r;
  logic        reqv_r;
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      req_r  <= '0;
      reqv_r <= 1'b0;
    end
    else if (mech_r == AGPTP_PIPE)
    begin
      reqv_r <= ~pipe_n;
      req_r  <= {ph_s_r.cbe_n, ph_s_r.ad};
    end
    else
    begin
      reqv_r <= sb_edge;
      req_r  <= {28'h0, sba_s_r};
    end
  end
  assign req_data  = req_r;
  assign req_valid = reqv_r;

  // ------------------------------------------------------------------
  // arbitration: grant with status
  // ------------------------------------------------------------------
  logic       gnt_r;
  logic [2:0] st_r;
  wire  rd_lo_block = rd_valid && !rd_high_prio && !rbf_n;
  wire  rd_return   = rd_valid && !rd_lo_block;
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      gnt_r <= 1'b1;
      st_r  <= ST_START;
    end
    else if (rd_return)
    begin
      gnt_r <= 1'b0;
      st_r  <= rd_high_prio ? ST_RD_HIGH : ST_RD_LOW;
    end
    else if (!req_s_r[1])
    begin
      gnt_r <= 1'b0;
      st_r  <= ST_START;
    end
    else
    begin
      gnt_r <= 1'b1;
      st_r  <= ST_START;
    end
  end
  assign port_grant_n = gnt_r;
  assign grant_status = st_r;

  // ------------------------------------------------------------------
  // frame protocol target state machine
  // ------------------------------------------------------------------
  typedef enum {T_IDLE, T_DECODE, T_DATA, T_STOP, T_TURN} agptp_tst_e;
  agptp_tst_e st_q, st_nxt;
  logic       wr_cyc_r;          // current transaction is a write
  logic [2:0] wait_r;            // clocks waited in data phase without transfer
  logic       devsel_r, trdy_r, stop_r, drive_r;
  logic [31:0] ad_r;
  logic        par_out_r, par_chk_r;  // pending parity check
  logic        perr_r;

  wire addr_phase = (st_q == T_IDLE) && !frame_n;
  wire hit = (ph_s_r.ad[31:WIN_BITS] == WIN_BASE[31:WIN_BITS]);
  wire cmd_ok = (ph_s_r.cbe_n == CMD_MEM_READ) || (ph_s_r.cbe_n == CMD_MEM_RD_MULT)
              || (ph_s_r.cbe_n == CMD_MEM_RD_LINE) || is_write(ph_s_r.cbe_n);
  wire fifo_in_ready;
  wire data_xfer = !trdy_r && !irdy_n;
  wire can_go = wr_cyc_r ? fifo_in_ready : rd_valid;
  wire other_sel = !devsel_s_r[1] && devsel_r;

  // next-state decode
  always_comb
  begin
    st_nxt = st_q;
    case (st_q)
      T_IDLE:   if (addr_phase) st_nxt = (hit && cmd_ok) ? T_DECODE : T_TURN;
      T_DECODE: st_nxt = T_DATA;
      T_DATA:   if (frame_n && data_xfer) st_nxt = T_TURN;
                else if (!can_go && wait_r == DEVSEL_WAIT) st_nxt = T_STOP;
      T_STOP:   if (frame_n) st_nxt = T_TURN;
      T_TURN:   st_nxt = T_IDLE;
      default:  st_nxt = T_IDLE;
    endcase
  end

  // state and handshake registers
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      st_q     <= T_IDLE;
      wr_cyc_r <= 1'b0;
      wait_r   <= '0;
      devsel_r <= 1'b1;
      trdy_r   <= 1'b1;
      stop_r   <= 1'b1;
      drive_r  <= 1'b0;
    end
    else
    begin
      st_q     <= st_nxt;
      if (addr_phase)
        wr_cyc_r <= is_write(ph_s_r.cbe_n);
      wait_r   <= (st_nxt == T_DATA && !data_xfer) ? 3'(wait_r + 3'h1) : 3'h0;
      devsel_r <= !(st_nxt == T_DATA || st_nxt == T_STOP);
      trdy_r   <= !(st_nxt == T_DATA && can_go);
      stop_r   <= !(st_nxt == T_STOP);
      drive_r  <= (st_nxt == T_DATA) && !wr_cyc_r && !(addr_phase);
    end
  end

  // read data and outgoing parity
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      ad_r      <= '0;
      par_out_r <= 1'b0;
    end
    else
    begin
      ad_r      <= rd_data;
      par_out_r <= even_par(ad_r, RD_RETURN_CBE);
    end
  end

  // parity check on write data, error one clock after parity
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      par_chk_r <= 1'b0;
      perr_r    <= 1'b1;
    end
    else
    begin
      par_chk_r <= wr_cyc_r && data_xfer && (mech_r == AGPTP_PIPE || 1'b1);
      perr_r    <= !(par_chk_r && (even_par(ph_s_r.ad, ph_s_r.cbe_n) != par_s_r[1]));
    end
  end

  assign rd_ready = !trdy_r && !irdy_n && !wr_cyc_r;

  // pin drivers; frame only sensed, pull-up is external to logic
  assign port_frame_n_o           = 1'b1;
  assign port_frame_n_oe          = 1'b0;
  assign port_target_ready_n_o    = trdy_r;
  assign port_target_ready_n_oe   = (st_q != T_IDLE);
  assign port_stop_n_o            = stop_r;
  assign port_stop_n_oe           = (st_q != T_IDLE);
  assign port_device_select_n_o   = devsel_r;
  assign port_device_select_n_oe  = (st_q != T_IDLE);
  assign port_parity_error_n_o    = perr_r;
  assign port_parity_error_n_oe   = !perr_r;
  assign port_addr_data_o         = ad_r;
  assign port_addr_data_oe        = drive_r;
  assign port_cmd_byte_en_n_o     = RD_RETURN_CBE;
  assign port_cmd_byte_en_n_oe    = drive_r;
  assign port_parity_o            = par_out_r;
  assign port_parity_oe           = drive_r;
  assign low_half_data_strobe_o   = 1'b0;
  assign low_half_data_strobe_oe  = drive_r;
  assign high_half_data_strobe_o  = 1'b0;
  assign high_half_data_strobe_oe = drive_r;
  assign locked_seen              = 1'b0;

  // ------------------------------------------------------------------
  // write data buffer
  // ------------------------------------------------------------------
  agptp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .sys_clk   (sys_clk),
    .rst       (port_rst),
    .in_data   ({ph_s_r.cbe_n, ph_s_r.ad}),
    .in_valid  (wr_cyc_r && data_xfer),
    .in_ready  (fifo_in_ready),
    .out_data  (wr_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_addr_hit;
    addr_phase && hit && cmd_ok;
  endsequence

  devsel_after_hit_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    s_addr_hit |-> ##2 !devsel_r)
    else $error("device select missing after hit");

  perr_timing_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    !perr_r |-> $past(par_chk_r))
    else $error("parity error without checked phase");

  cbe_zero_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    port_cmd_byte_en_n_oe |-> port_cmd_byte_en_n_o == 4'h0)
    else $error("nonzero byte enables on read return");

  frame_release_a: assert property (@(posedge sys_clk)
    !port_frame_n_oe)
    else $error("frame driven by target");

  trdy_needs_data_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    (!trdy_r && !wr_cyc_r) |-> $past(rd_valid))
    else $error("target ready without read data");

  stop_hold_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    (!stop_r && !frame_n) |=> !stop_r)
    else $error("stop dropped before frame end");

  rbf_block_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    (rd_valid && !rd_high_prio && !rbf_n) |=> st_r != ST_RD_LOW || gnt_r)
    else $error("low priority read granted while buffer full");

  mech_fixed_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    $past(cfg_done_r) |-> $stable(mech_r))
    else $error("enqueue mechanism changed");

  pipe_capture_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    (mech_r == AGPTP_PIPE && !pipe_n && cfg_done_r) |=> req_valid)
    else $error("pipelined request not captured");

  serr_fwd_a: assert property (@(posedge sys_clk) disable iff (port_rst)
    (serr_s_r[1] == 1'b0)[*3] |=> ##[0:2] !pci_system_error_n)
    else $error("system error not forwarded");

  reset_hold_a: assert property (@(posedge sys_clk)
    system_reset_in_n_r[1] |=> (st_q == T_IDLE && port_grant_n))
    else $error("port logic not reset");
endmodule

// [tb/agptp_gfx_model.sv]
// behavioural graphics master driving the port pins of the target
`timescale 1ns/1ps
module agptp_gfx_model
  import agptp_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  trdy_n,
  output logic       frame_n,
  output logic       irdy_n,
  output logic [31:0] ad,
  output logic [3:0] cbe_n,
  output logic       par,
  output logic       pipe_n,
  output logic       sb_strobe,
  output logic [7:0] sba
);
  // ----------------------------------------
  // idle levels: frame pulled high, strobe parked
  // ----------------------------------------
  initial
  begin
    frame_n   = 1'b1;
    irdy_n    = 1'b1;
    ad        = 32'hFFFF_0000;
    cbe_n     = 4'hA;
    par       = 1'b0;
    pipe_n    = 1'b1;
    sb_strobe = 1'b0;
    sba       = 8'hC3;
  end

  // single-phase memory write, optional parity fault
  task automatic frame_write(input logic [31:0] addr, input logic [31:0] data,
                             input logic [3:0] be, input logic bad, output logic ok);
    int n;
    @(posedge sys_clk);
    #1 frame_n = 1'b0;
    ad = addr;
    cbe_n = CMD_MEM_WRITE;
    par = ^{addr, CMD_MEM_WRITE};
    @(posedge sys_clk);
    #1 frame_n = 1'b1;
    irdy_n = 1'b0;
    ad = data;
    cbe_n = be;
    par = (^{data, be}) ^ bad;
    n = 0;
    // hold the phase until target-ready is sampled low
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (trdy_n !== 1'b0 && n < 40);
    ok = (n < 40);
    #1 irdy_n = 1'b1;
    // released bus shows the inverse so stale data never matches
    ad = ~data;
    cbe_n = ~be;
    par = ~par;
  endtask

  // single-phase memory read; target drives the data word back
  task automatic frame_read(input logic [31:0] addr, output logic ok);
    int n;
    @(posedge sys_clk);
    #1 frame_n = 1'b0;
    ad = addr;
    cbe_n = CMD_MEM_READ;
    par = ^{addr, CMD_MEM_READ};
    @(posedge sys_clk);
    #1 frame_n = 1'b1;
    irdy_n = 1'b0;
    cbe_n = 4'h0;
    n = 0;
    // hold the request until target-ready is sampled low
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (trdy_n !== 1'b0 && n < 40);
    ok = (n < 40);
    #1 irdy_n = 1'b1;
    cbe_n = 4'hF;
  endtask

  // pipelined enqueue, one request each clock
  task automatic pipe_enq(input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      @(posedge sys_clk);
      #1 pipe_n = 1'b0;
      ad = 32'h0000_1000 + 32'(i);
      cbe_n = 4'h1;
    end
    @(posedge sys_clk);
    #1 pipe_n = 1'b1;
    ad = ~ad;
  endtask

  // sideband byte with one strobe period of 320 ns
  task automatic sb_enq(input logic [7:0] b);
    @(posedge sys_clk);
    #1 sba = b;
    #160 sb_strobe = 1'b1;
    #160 sb_strobe = 1'b0;
    #160 sba = ~b;
  endtask
endmodule

// [tb/tb_agptp_target.sv]
// self-checking bench for the graphics port target
`timescale 1ns/1ps
module tb_agptp_target
  import agptp_pkg::*;
;
  logic sys_clk = 0, rst = 1, system_reset_in_n = 1, cfg_sideband_mode = 0;
  logic read_buffer_full_n = 1, port_system_error_n = 1, port_request_n = 1;
  logic wr_ready = 1, rd_valid = 0, rd_high_prio = 0;
  logic [31:0] rd_data = 32'h0;
  logic m_frame, port_initiator_ready_n, port_pipe_n, sideband_strobe, m_par, ok;
  logic [31:0] m_ad;
  logic [3:0] m_cbe;
  logic [7:0] sideband_address_bus;
  logic port_frame_n_o, port_frame_n_oe, port_target_ready_n_o, port_target_ready_n_oe;
  logic port_stop_n_o, port_stop_n_oe, port_device_select_n_o, port_device_select_n_oe;
  logic port_parity_error_n_o, port_parity_error_n_oe, port_grant_n, port_addr_data_oe;
  logic port_cmd_byte_en_n_oe, port_parity_o, port_parity_oe, low_half_data_strobe_o;
  logic low_half_data_strobe_oe, high_half_data_strobe_o, high_half_data_strobe_oe;
  logic wr_valid, rd_ready, req_valid, req_sideband, locked_seen, pci_system_error_n;
  logic [2:0] grant_status;
  logic [31:0] port_addr_data_o;
  logic [3:0] port_cmd_byte_en_n_o;
  logic [35:0] wr_data, req_data, last_req, last_rd;
  int failures = 0, checks = 0, n, req_cnt, perr_cnt, dev_cnt, bad_rd, held, rd_cnt;
  // ----------------------------------------
  // wire resolution, pull-ups where nobody drives
  // ----------------------------------------
  wire port_frame_n_i = port_frame_n_oe ? port_frame_n_o : m_frame;
  wire [31:0] port_addr_data_i = port_addr_data_oe ? port_addr_data_o : m_ad;
  wire [3:0] port_cmd_byte_en_n_i = port_cmd_byte_en_n_oe ? port_cmd_byte_en_n_o : m_cbe;
  wire port_parity_i = port_parity_oe ? port_parity_o : m_par;
  wire trdy_w = port_target_ready_n_oe ? port_target_ready_n_o : 1'b1;
  wire port_device_select_n_i = port_device_select_n_oe ? port_device_select_n_o : 1'b1;
  wire port_parity_error_n_i = port_parity_error_n_oe ? port_parity_error_n_o : 1'b1;

  agptp_target i_agptp_target (.sys_clk, .system_reset_in_n, .rst, .cfg_sideband_mode,
    .sideband_strobe, .sideband_address_bus, .port_pipe_n, .read_buffer_full_n,
    .port_frame_n_i, .port_frame_n_o, .port_frame_n_oe, .port_initiator_ready_n,
    .port_target_ready_n_o, .port_target_ready_n_oe, .port_stop_n_o, .port_stop_n_oe,
    .port_device_select_n_i, .port_device_select_n_o, .port_device_select_n_oe,
    .port_parity_error_n_i, .port_parity_error_n_o, .port_parity_error_n_oe,
    .port_system_error_n, .port_request_n, .port_grant_n, .grant_status,
    .port_addr_data_i, .port_addr_data_o, .port_addr_data_oe, .port_cmd_byte_en_n_i,
    .port_cmd_byte_en_n_o, .port_cmd_byte_en_n_oe, .port_parity_i, .port_parity_o,
    .port_parity_oe, .low_half_data_strobe_o, .low_half_data_strobe_oe,
    .high_half_data_strobe_o, .high_half_data_strobe_oe, .wr_data, .wr_valid, .wr_ready,
    .rd_data, .rd_valid, .rd_high_prio, .rd_ready, .req_data, .req_valid, .req_sideband,
    .locked_seen, .pci_system_error_n);

  agptp_gfx_model i_agptp_gfx_model (.sys_clk(sys_clk), .trdy_n(trdy_w), .frame_n(m_frame),
    .irdy_n(port_initiator_ready_n), .ad(m_ad), .cbe_n(m_cbe), .par(m_par),
    .pipe_n(port_pipe_n), .sb_strobe(sideband_strobe), .sba(sideband_address_bus));

  always #20 sys_clk = ~sys_clk;

  // ----------------------------------------
  // monitors counting pin events per clock
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (req_valid === 1'b1)
    begin
      req_cnt++;
      last_req = req_data;
    end
    if (port_parity_error_n_oe === 1'b1 && port_parity_error_n_o === 1'b0) perr_cnt++;
    if (port_device_select_n_oe === 1'b1 && port_device_select_n_o === 1'b0) dev_cnt++;
    // read return: zero enables and both strobes driven
    if (port_addr_data_oe === 1'b1 && (port_cmd_byte_en_n_o !== RD_RETURN_CBE
        || low_half_data_strobe_oe !== 1'b1 || high_half_data_strobe_oe !== 1'b1
        || port_parity_oe !== 1'b1 || port_parity_o !== ^port_addr_data_o)) bad_rd++;
    if (port_addr_data_oe === 1'b1) last_rd = {port_cmd_byte_en_n_o, port_addr_data_o};
    if (rd_ready === 1'b1) rd_cnt++;
    if (port_grant_n === 1'b0 && grant_status === ST_RD_LOW && read_buffer_full_n === 1'b0)
      held++;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // bounded wait for a level, sampled after the edge settles
  task automatic wait_lvl(ref logic s, input logic lvl);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #2 n++;
    end
    while (s !== lvl && n < 40);
  endtask

  task automatic do_reset(input logic sb);
    @(posedge sys_clk);
    #1 rst = !sb;
    system_reset_in_n = !sb;
    cfg_sideband_mode = sb;
    repeat (6) @(posedge sys_clk);
    chk({port_grant_n, grant_status, port_parity_error_n_o, pci_system_error_n},
        {1'b1, ST_START, 2'b11}, "reset outputs");
    chk({port_frame_n_oe, port_target_ready_n_oe, port_stop_n_oe, port_device_select_n_oe,
         port_addr_data_oe, port_parity_oe}, 6'h00, "reset enables");
    #1 rst = 1'b0;
    system_reset_in_n = 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_write;
    {dev_cnt, perr_cnt} = 0;
    #1 wr_ready = 1'b0;
    i_agptp_gfx_model.frame_write(32'h0000_0100, 32'hA5C3_1E70, 4'h0, 1'b0, ok);
    wait_lvl(wr_valid, 1'b1);
    chk(wr_data, {4'h0, 32'hA5C3_1E70}, "write word");
    wr_ready = 1'b1;
    chk({ok, dev_cnt > 0, perr_cnt == 0}, 3'b111, "write handshake");
    repeat (4) @(posedge sys_clk);
    perr_cnt = 0;
    i_agptp_gfx_model.frame_write(32'h0000_0200, 32'h0F0F_1234, 4'h3, 1'b1, ok);
    repeat (12) @(posedge sys_clk);
    chk(perr_cnt, 36'h1, "parity error pulse");
    dev_cnt = 0;
    i_agptp_gfx_model.frame_write(32'h1000_0000, 32'h1, 4'h0, 1'b0, ok);
    repeat (6) @(posedge sys_clk);
    chk({ok, dev_cnt == 0}, 2'b01, "out of window ignored");
  endtask

  // fill the fifo while stalled, then drain in order
  task automatic t_fifo;
    wr_ready = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++)
      i_agptp_gfx_model.frame_write(32'h0000_0400, 32'h0000_5500 + 32'(i), 4'h0, 1'b0, ok);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      wait_lvl(wr_valid, 1'b1);
      chk(wr_data, {4'h0, 32'h0000_5500 + 32'(i)}, "fifo order");
      #1 wr_ready = 1'b1;
      @(posedge sys_clk);
      #1 wr_ready = 1'b0;
    end
    #1 wr_ready = 1'b1;
  endtask

  task automatic t_pipe;
    req_cnt = 0;
    i_agptp_gfx_model.pipe_enq(3);
    repeat (6) @(posedge sys_clk);
    chk(req_cnt, 36'h3, "pipelined count");
    chk(last_req, {4'h1, 32'h0000_1002}, "pipelined request");
    chk(req_sideband, 36'h0, "pipelined mechanism");
  endtask

  task automatic t_grant;
    held = 0;
    bad_rd = 0;
    rd_cnt = 0;
    #1 read_buffer_full_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rd_valid = 1'b1;
    rd_data = 32'h3C3C_0001;
    repeat (12) @(posedge sys_clk);
    chk(held, 36'h0, "low read held while full");
    #1 read_buffer_full_n = 1'b1;
    wait_lvl(port_grant_n, 1'b0);
    chk({port_grant_n, grant_status}, {1'b0, ST_RD_LOW}, "read grant");
    i_agptp_gfx_model.frame_read(32'h0000_0300, ok);
    #1 rd_valid = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({ok, rd_cnt == 1}, 2'b11, "read handshake");
    chk(last_rd, {RD_RETURN_CBE, 32'h3C3C_0001}, "read word");
    chk(bad_rd, 36'h0, "read return lines");
    #1 port_request_n = 1'b0;
    wait_lvl(port_grant_n, 1'b0);
    chk({port_grant_n, grant_status}, {1'b0, ST_START}, "start grant");
    #1 port_request_n = 1'b1;
    #1 port_system_error_n = 1'b0;
    wait_lvl(pci_system_error_n, 1'b0);
    chk(n < 12, 1'b1, "system error forwarded");
    #1 port_system_error_n = 1'b1;
  endtask

  task automatic t_sideband;
    do_reset(1'b1);
    req_cnt = 0;
    i_agptp_gfx_model.sb_enq(8'h5A);
    repeat (8) @(posedge sys_clk);
    chk({req_cnt == 1, req_sideband}, 2'b11, "sideband request");
    chk(last_req, {28'h0, 8'h5A}, "sideband address");
  endtask

  task automatic close_out;
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #400000 failures++;
    close_out;
  end

  initial
  begin
    do_reset(1'b0);
    t_write;
    t_fifo;
    t_pipe;
    t_grant;
    t_sideband;
    close_out;
  end
endmodule
